// ### cgoc_pkg.sv
// Package for the column gain/offset correction stage
// Assumes a plain register port with one-cycle read latency
package cgoc_pkg;
  // Register offsets (word addresses on the plain port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_COLUMN = 4'h2;
  localparam logic [3:0] REG_GAIN = 4'h3;
  localparam logic [3:0] REG_OFFSET = 4'h4;
  localparam logic [3:0] REG_CMD = 4'h5;
  localparam logic [3:0] REG_FACT_GAIN = 4'h6;
  localparam logic [3:0] REG_FACT_OFFSET = 4'h7;
  // CTRL fields
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_SRC_LO = 1;
  // STATUS fields
  localparam int ST_ERR_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_SAVED_BIT = 2;
  localparam int ST_EFF_ON_BIT = 3;
  // CMD fields
  localparam int CMD_RELOAD_BIT = 0;
  localparam int CMD_STORE_BIT = 1;
  localparam int CMD_ERRCLR_BIT = 2;
  // Gain format: unsigned fixed point, GAIN_FRAC fraction bits
  localparam int GAIN_W = 16;
  localparam int GAIN_FRAC = 14;
  localparam logic [15:0] GAIN_UNITY = 16'h4000;
  localparam logic [15:0] OFFSET_ZERO = 16'h0000;
  localparam int OFFSET_STEP_LOG2 = 5;
  localparam int PIX_W = 16;
  localparam int GAIN_LEVELS = 4;
  typedef enum logic [1:0] {
    SRC_FACTORY = 2'h0,
    SRC_USER = 2'h1,
    SRC_CALIB = 2'h2
  } cgoc_src_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RELOAD = 3'b010,
    ST_STORE = 3'b100
  } cgoc_state_e;
  typedef struct packed {
    logic [15:0] gain;
    logic [15:0] offset;
  } cgoc_coef_s;
  typedef struct packed {
    logic valid;
    logic sol;
    logic [15:0] data;
  } cgoc_pix_s;
endpackage

// ### cgoc_properties.sv
// Port checker for the correction stage
// Assumes it is bound to cgoc_top
`timescale 1ns/1ns
module cgoc_check
  import cgoc_pkg::*;
(
  // Clock, reset, register port
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // Pixels
  input wire cgoc_pix_s PIX_IN,
  input wire cgoc_pix_s PIX_OUT
);
  logic [2:0] ctrl;
  wire logic cal = ctrl[2:1] == SRC_CALIB;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Shadow of the control register
  always_ff @(posedge CLOCK)
    if (RST) ctrl <= 3'h1;
    else if (WR && ADDR == REG_CTRL) begin
      ctrl[0] <= WDATA[0];
      if (WDATA[2:1] != 2'h3) ctrl[2:1] <= WDATA[2:1];
    end
  property p_idle;
    !RD |=> RDATA == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("stray data");
  property p_beat;
    PIX_IN.valid |=> PIX_OUT.valid && PIX_OUT.sol == $past(PIX_IN.sol);
  endproperty
  a_beat: assert property (p_beat) else $error("beat lost");
  property p_gap;
    !PIX_IN.valid |=> !PIX_OUT.valid;
  endproperty
  a_gap: assert property (p_gap) else $error("extra beat");
  property p_pass;
    PIX_IN.valid && (!ctrl[0] || cal) |=> PIX_OUT.data == $past(PIX_IN.data);
  endproperty
  a_pass: assert property (p_pass) else $error("not bypassed");
  property p_eff;
    RD && ADDR == REG_STATUS && cal |=> !RDATA[ST_EFF_ON_BIT];
  endproperty
  a_eff: assert property (p_eff) else $error("still on");
  property p_hide;
    RD && ADDR == REG_GAIN && !cal |=> RDATA == 32'h0;
  endproperty
  a_hide: assert property (p_hide) else $error("read allowed");
  property p_err;
    WR && ADDR == REG_GAIN && !cal ##[1:4] RD && ADDR == REG_STATUS
      |=> RDATA[ST_ERR_BIT];
  endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_step;
    WR && ADDR == REG_OFFSET && WDATA[4:0] != 5'h0 ##[1:4]
      RD && ADDR == REG_STATUS |=> RDATA[ST_ERR_BIT];
  endproperty
  a_step: assert property (p_step) else $error("step kept");
endmodule
bind cgoc_top cgoc_check i_cgoc_check (.CLOCK(CLOCK), .RST(RST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .PIX_IN(PIX_IN), .PIX_OUT(PIX_OUT));

// ### cgoc_top.sv
// Column gain/offset correction stage with user, saved and factory tables
// Assumes a pixel stream on CLOCK with a start-of-line flag per line
//
// Operation
// - Enable bit bypasses or applies correction
// - Source select: factory, user, calibration
// - User table access only during calibration; factory table writable at any time
// - Column index selects entry, resets zero
// - Gain of indexed column readable, writable
// - 16-bit offset of indexed column readable
// - Reload restores saved table or neutral
// - Store copies user table to storage
// - Store overwrites the single saved copy
// - Output equals gain times (pixel plus offset), saturated to 16 bits
// - Calibration forces correction off
// - Factory set follows sensor gain level
// - Offset not multiple of step rejected
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module cgoc_top
  import cgoc_pkg::*;
#(
  parameter int COLS = 64,
  parameter int CW = 6
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Sensor gain level from exposure logic
  input wire logic [1:0] SENSOR_GAIN_LEVEL,
  // Pixel stream
  input wire cgoc_pix_s PIX_IN,
  output cgoc_pix_s PIX_OUT
);
  // Entry that applies no correction
  localparam cgoc_coef_s coef_neutral = '{GAIN_UNITY, OFFSET_ZERO};
  // Working, saved (non-volatile image) and factory tables
  cgoc_coef_s user_tab [COLS];
  cgoc_coef_s save_tab [COLS];
  cgoc_coef_s fact_tab [GAIN_LEVELS*COLS];
  logic correction_on;
  cgoc_src_e coefficient_source_select;
  logic [CW-1:0] column_index;
  logic saved_valid;
  logic offset_err;
  cgoc_state_e state;
  logic [CW-1:0] walk;
  logic [CW-1:0] col;
  logic [CW-1:0] next_col;
  logic [31:0] rdata_q;

  function automatic logic is_wr(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  wire calib = coefficient_source_select == SRC_CALIB;
  wire busy = state != ST_IDLE;
  wire tab_ok = calib && !busy;
  wire wr_ctrl = WR && is_wr(ADDR, REG_CTRL);
  wire wr_col = WR && is_wr(ADDR, REG_COLUMN);
  wire wr_gain = WR && is_wr(ADDR, REG_GAIN) && tab_ok;
  wire off_bad = WDATA[OFFSET_STEP_LOG2-1:0] != '0;
  wire off_try = WR && is_wr(ADDR, REG_OFFSET);
  wire wr_off = off_try && tab_ok && !off_bad;
  wire wr_cmd = WR && is_wr(ADDR, REG_CMD);
  wire cmd_reload = wr_cmd && WDATA[CMD_RELOAD_BIT] && tab_ok;
  wire cmd_store = wr_cmd && WDATA[CMD_STORE_BIT] && tab_ok;
  wire err_set = (off_try && (off_bad || !tab_ok))
      || ((WR && is_wr(ADDR, REG_GAIN)) && !tab_ok)
      || (wr_cmd && (WDATA[CMD_RELOAD_BIT] || WDATA[CMD_STORE_BIT])
          && !tab_ok);
  wire err_clr = wr_cmd && WDATA[CMD_ERRCLR_BIT];
  wire [1:0] src_req = WDATA[CTRL_SRC_LO +: 2];
  wire src_legal = src_req != 2'h3;
  wire eff_on = correction_on && !calib;
  wire cgoc_coef_s user_cur = user_tab[column_index];
  wire [31:0] rd_mux =
      is_wr(ADDR, REG_CTRL) ? {29'h0, coefficient_source_select,
                               correction_on} :
      is_wr(ADDR, REG_STATUS) ? {28'h0, eff_on, saved_valid, busy,
                                 offset_err} :
      is_wr(ADDR, REG_COLUMN) ? {{(32-CW){1'b0}}, column_index} :
      (is_wr(ADDR, REG_GAIN) && tab_ok) ? {16'h0, user_cur.gain} :
      (is_wr(ADDR, REG_OFFSET) && tab_ok) ? {16'h0, user_cur.offset} :
      32'h0;

  // Control registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      correction_on <= 1'b1;
      coefficient_source_select <= SRC_FACTORY;
      column_index <= '0;
      offset_err <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        correction_on <= WDATA[CTRL_ON_BIT];
        if (src_legal)
          coefficient_source_select <= cgoc_src_e'(src_req);
      end
      if (wr_col)
        column_index <= WDATA[CW-1:0];
      if (err_set)
        offset_err <= 1'b1;
      else if (err_clr)
        offset_err <= 1'b0;
    end
  end

  // Command sequencer walks every column
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state <= ST_IDLE;
      walk <= '0;
      saved_valid <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          walk <= '0;
          if (cmd_store)
            state <= ST_STORE;
          else if (cmd_reload)
            state <= ST_RELOAD;
        end
        ST_RELOAD, ST_STORE: begin
          walk <= walk + 1'b1;
          if (walk == CW'(COLS - 1)) begin
            if (state == ST_STORE)
              saved_valid <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Table memories; save_tab stands for the non-volatile image
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      for (int i = 0; i < COLS; i++)
        user_tab[i] <= '{GAIN_UNITY, OFFSET_ZERO};
    end else if (state == ST_RELOAD) begin
      user_tab[walk] <= saved_valid ? save_tab[walk] : coef_neutral;
    end else begin
      if (wr_gain)
        user_tab[column_index].gain <= WDATA[GAIN_W-1:0];
      if (wr_off)
        user_tab[column_index].offset <= WDATA[15:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (state == ST_STORE)
      save_tab[walk] <= user_tab[walk];
  end

  // Factory table written through its own registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      for (int i = 0; i < GAIN_LEVELS*COLS; i++)
        fact_tab[i] <= '{GAIN_UNITY, OFFSET_ZERO};
    end else if (WR && is_wr(ADDR, REG_FACT_GAIN)) begin
      fact_tab[{WDATA[17:16], column_index}].gain <= WDATA[15:0];
    end else if (WR && is_wr(ADDR, REG_FACT_OFFSET)) begin
      fact_tab[{WDATA[17:16], column_index}].offset <= WDATA[15:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST)
      rdata_q <= '0;
    else if (RD)
      rdata_q <= rd_mux;
    else
      rdata_q <= '0;
  end
  assign RDATA = rdata_q;

  assign next_col = PIX_IN.sol ? CW'(1) : col + 1'b1;
  wire [CW-1:0] pix_col = PIX_IN.sol ? '0 : col;
  always_ff @(posedge CLOCK) begin
    if (RST)
      col <= '0;
    else if (PIX_IN.valid)
      col <= next_col;
  end

  wire cgoc_coef_s fcoef = fact_tab[{SENSOR_GAIN_LEVEL, pix_col}];
  wire cgoc_coef_s coef = (coefficient_source_select == SRC_USER)
      ? user_tab[pix_col] : fcoef;
  wire [16:0] sum = {1'b0, PIX_IN.data} + {1'b0, coef.offset};
  wire [32:0] prod = sum * coef.gain;
  wire [32:0] scaled = prod >> GAIN_FRAC;
  wire [15:0] corr = (scaled[32:16] != '0) ? 16'hffff : scaled[15:0];

  cgoc_pix_s pix_q;
  always_ff @(posedge CLOCK) begin
    if (RST)
      pix_q <= '0;
    else begin
      pix_q.valid <= PIX_IN.valid;
      pix_q.sol <= PIX_IN.sol;
      pix_q.data <= eff_on ? corr : PIX_IN.data;
    end
  end
  assign PIX_OUT = pix_q;
endmodule

// ### cgoc_top_bench.sv
// Bench for the correction stage
// Assumes the checker file is compiled with it
`timescale 1ns/1ns
module cgoc_top_bench;
  import cgoc_pkg::*;
  logic clk, rst, wr, rd;
  logic [3:0] adr;
  logic [1:0] lvl;
  logic [31:0] wd, rdat, v;
  cgoc_pix_s pin, pout;
  int n_errors, n_checks, cyc;
  cgoc_top #(.COLS(8), .CW(3)) i_cgoc_top (.CLOCK(clk), .RST(rst),
    .ADDR(adr), .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdat),
    .SENSOR_GAIN_LEVEL(lvl), .PIX_IN(pin), .PIX_OUT(pout));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %0t: %h not %h", $time, s, e);
    end
  endtask
  task automatic wrr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask
  // Four pixels from column 0, column 2 expects e
  task automatic line(input logic [15:0] d, input logic [15:0] e);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pin <= '{1'b1, i == 0, d};
      @(posedge clk);
      pin <= '0;
      #1 chk({16'h0, pout.data}, {16'h0, i == 2 ? e : d});
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      complete_run;
    end
  end
  initial begin
    {rst, wr, rd, adr, wd, lvl, pin} = {1'b1, 58'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdr(REG_CTRL);
    chk(v, 32'h1);
    rdr(REG_COLUMN);
    chk(v, 32'h0);
    // Column 2 factory gain differs per sensor gain level
    wrr(REG_COLUMN, 32'h2);
    for (int g = 0; g < 4; g++)
      wrr(REG_FACT_GAIN, (g << 16) | ((g + 1) << 12));
    for (int g = 0; g < 4; g++) begin
      @(posedge clk);
      lvl <= g[1:0];
      line(16'h1234, 16'(16'h48d * (g + 1)));
    end
    wrr(REG_GAIN, 32'h8000);
    rdr(REG_STATUS);
    chk(v, 32'h9);
    wrr(REG_CMD, 32'h4);
    wrr(REG_CTRL, 32'h5);
    rdr(REG_STATUS);
    chk(v, 32'h0);
    wrr(REG_COLUMN, 32'h2);
    wrr(REG_OFFSET, 32'h20);
    wrr(REG_OFFSET, 32'h21);
    rdr(REG_STATUS);
    chk(v, 32'h1);
    wrr(REG_CMD, 32'h4);
    rdr(REG_OFFSET);
    chk(v, 32'h20);
    line(16'h100, 16'h100);
    // Reload with nothing saved gives neutral entries
    wrr(REG_CMD, 32'h1);
    repeat (10) @(posedge clk);
    rdr(REG_OFFSET);
    chk(v, 32'h0);
    wrr(REG_OFFSET, 32'h20);
    // Second store must replace the first saved copy
    for (int k = 0; k < 2; k++) begin
      wrr(REG_GAIN, k ? 32'h6000 : 32'h8000);
      rdr(REG_GAIN);
      chk(v, k ? 32'h6000 : 32'h8000);
      wrr(REG_CMD, 32'h2);
      repeat (10) @(posedge clk);
      rdr(REG_STATUS);
      chk(v, 32'h4);
      wrr(REG_GAIN, 32'h4000);
      wrr(REG_CMD, 32'h1);
      repeat (10) @(posedge clk);
      rdr(REG_GAIN);
      chk(v, k ? 32'h6000 : 32'h8000);
    end
    wrr(REG_CTRL, 32'h3);
    line(16'h100, 16'h1b0);
    wrr(REG_CTRL, 32'h2);
    line(16'h100, 16'h100);
    complete_run;
  end
endmodule
